// File: common/pwr_seq_pkg.sv
// Constants, encodings and state type for the power-state sequencer
package pwr_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned KEY_DB_SHORT_US = 200;
  localparam int unsigned KEY_DB_LONG_MS = 30;
  localparam int unsigned SHIP_EXIT_MS = 250;
  localparam int unsigned HARD_RST_SHORT_S = 8;
  localparam int unsigned HARD_RST_LONG_S = 16;
  localparam int unsigned KEY_DB_SHORT_CYC = (CLK_HZ / 1_000_000) * KEY_DB_SHORT_US;
  localparam int unsigned KEY_DB_LONG_CYC = (CLK_HZ / 1_000) * KEY_DB_LONG_MS;
  localparam int unsigned SHIP_EXIT_CYC = (CLK_HZ / 1_000) * SHIP_EXIT_MS;
  localparam int unsigned HARD_RST_SHORT_CYC = CLK_HZ * HARD_RST_SHORT_S;
  localparam int unsigned HARD_RST_LONG_CYC = CLK_HZ * HARD_RST_LONG_S;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SW_CMD_NONE = 2'h0;
  localparam logic [1:0] SW_CMD_COLD_RST = 2'h1;
  localparam logic [1:0] SW_CMD_OFF = 2'h2;
  localparam logic [1:0] SW_CMD_SHIP = 2'h3;
  localparam logic [1:0] REG_MODE_OFF = 2'h0;
  localparam logic [1:0] REG_MODE_ON = 2'h1;
  localparam logic [1:0] REG_MODE_KEY = 2'h2;
  localparam logic [1:0] CHG_DTLS_NONE = 2'h0;
  localparam logic [1:0] CHG_DTLS_VALID = 2'h3;
  localparam logic [1:0] SINK_FS_OFF = 2'h0;
  localparam logic [3:0] MUX_OFF = 4'h0;
  localparam logic KEY_PUSH_BUTTON = 1'b0;
  localparam logic KEY_RELEASED = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_ship,
    st_shutdown,
    st_off_act,
    st_reset_act,
    st_standby,
    st_res_on
  } pwr_state_t;

endpackage

// File: common/key_if.sv
// Interface between the on-key debouncer and the sequencer
`timescale 1ns/1ns
interface key_if;
  logic raw_n;
  logic long_sel;
  logic level_n;
  logic rise;
  logic fall;

  modport deb (
    input raw_n,
    input long_sel,
    output level_n,
    output rise,
    output fall
  );

  modport user (
    output raw_n,
    output long_sel,
    input level_n,
    input rise,
    input fall
  );
endinterface

// File: src/key_debouncer.sv
// Two-edge debouncer for the active-low on-key input
`timescale 1ns/1ns
module key_debouncer #(
  parameter int unsigned SHORT_CYC = pwr_seq_pkg::KEY_DB_SHORT_CYC,
  parameter int unsigned LONG_CYC = pwr_seq_pkg::KEY_DB_LONG_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Key link
  key_if.deb key
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic level_r;
  logic level_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;
  logic [31:0] limit;

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  always_comb begin
    limit = key.long_sel ? 32'(LONG_CYC - 1) : 32'(SHORT_CYC - 1);
    cnt_nxt = '0;
    level_nxt = level_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    if (key.raw_n != level_r) begin
      // Both edges must hold for the full time before the level moves
      if (cnt_r >= limit) begin
        level_nxt = key.raw_n;
        rise_nxt = key.raw_n;
        fall_nxt = ~key.raw_n;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
      level_r <= pwr_seq_pkg::KEY_RELEASED;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign key.level_n = level_r;
  assign key.rise = rise_r;
  assign key.fall = fall_r;

endmodule

// File: src/power_state_sequencer.sv
// Power-state sequencer with on-key handling and hard-reset timer
`timescale 1ns/1ns
module power_state_sequencer #(
  parameter int unsigned KEY_DB_SHORT_CYC = pwr_seq_pkg::KEY_DB_SHORT_CYC,
  parameter int unsigned KEY_DB_LONG_CYC = pwr_seq_pkg::KEY_DB_LONG_CYC,
  parameter int unsigned SHIP_EXIT_CYC = pwr_seq_pkg::SHIP_EXIT_CYC,
  parameter int unsigned HARD_RST_SHORT_CYC = pwr_seq_pkg::HARD_RST_SHORT_CYC,
  parameter int unsigned HARD_RST_LONG_CYC = pwr_seq_pkg::HARD_RST_LONG_CYC
) (
  // Clock and power-on reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // On-key
  input wire logic on_key_n_in,
  input wire logic key_debounce_sel_in,
  input wire logic key_switch_type_in,
  input wire logic hard_reset_time_sel_in,
  // Software control
  input wire logic [1:0] software_power_command_in,
  input wire logic [1:0] regulator_enable_mode_in,
  input wire logic [1:0] regulator_enable_default_in,
  input wire logic [3:0] analog_mux_select_in,
  input wire logic sink_master_enable_in,
  input wire logic [1:0] sink_full_scale_sel_1_in,
  input wire logic [1:0] sink_full_scale_sel_2_in,
  // Analog status
  input wire logic [1:0] charger_input_details_in,
  input wire logic watchdog_expire_in,
  input wire logic overtemp_lockout_in,
  input wire logic sys_undervoltage_in,
  input wire logic sys_overvoltage_in,
  input wire logic sys_below_exit_in,
  // Status and control outputs
  output logic [2:0] power_state_out,
  output logic bias_enable_out,
  output logic regulator_on_out,
  output logic battery_disconnect_out,
  output logic host_access_block_out,
  output logic system_register_reset_out,
  output logic sink_final_enable_out,
  output logic watchdog_expired_flag_out,
  output logic hard_reset_flag_out,
  output logic regulator_wake_flag_out,
  output logic software_wake_flag_out,
  output logic key_status_mirror_out,
  output logic key_rise_irq_out,
  output logic key_fall_irq_out
);

  // ----------------------------------------------------------------
  // Key debouncer
  // ----------------------------------------------------------------
  key_if key ();

  assign key.raw_n = on_key_n_in;
  assign key.long_sel = key_debounce_sel_in;

  key_debouncer #(
    .SHORT_CYC(KEY_DB_SHORT_CYC),
    .LONG_CYC(KEY_DB_LONG_CYC)
  ) u_key_debouncer (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .key(key.deb)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pwr_seq_pkg::pwr_state_t state_r;
  pwr_seq_pkg::pwr_state_t state_nxt;
  logic reg_on_r;
  logic reg_on_nxt;
  logic system_register_reset_r;
  logic system_register_reset_nxt;
  logic wdt_flag_r;
  logic wdt_flag_nxt;
  logic hr_flag_r;
  logic hr_flag_nxt;
  logic reg_wake_r;
  logic reg_wake_nxt;
  logic sw_wake_r;
  logic sw_wake_nxt;
  logic sink_en_r;
  logic sink_en_nxt;
  logic [1:0] chg_prev_r;
  logic [31:0] hr_cnt_r;
  logic [31:0] hr_cnt_nxt;
  logic [31:0] ship_cnt_r;
  logic [31:0] ship_cnt_nxt;
  logic ship_key_done_r;
  logic ship_key_done_nxt;

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  logic chg_valid;
  logic chg_rose;
  logic fault;
  logic off_cause;
  logic hard_off;
  logic sink_req;
  logic resource_req;
  logic reg_req;
  logic reg_down_req;
  logic hr_count_lvl;
  logic [31:0] hr_limit;
  logic wake_event;
  logic down_act;

  always_comb begin
    chg_valid = charger_input_details_in == pwr_seq_pkg::CHG_DTLS_VALID;
    chg_rose = chg_valid && chg_prev_r == pwr_seq_pkg::CHG_DTLS_NONE;
    fault = overtemp_lockout_in | sys_undervoltage_in | sys_overvoltage_in;
    hard_off = wdt_flag_r | hr_flag_r;
    off_cause = fault | hard_off
      | (software_power_command_in != pwr_seq_pkg::SW_CMD_NONE);
    sink_req = sink_master_enable_in
      && (sink_full_scale_sel_1_in != pwr_seq_pkg::SINK_FS_OFF
      || sink_full_scale_sel_2_in != pwr_seq_pkg::SINK_FS_OFF);
    reg_req = regulator_enable_mode_in == pwr_seq_pkg::REG_MODE_ON
      || reg_wake_r || sw_wake_r;
    reg_down_req = regulator_enable_mode_in == pwr_seq_pkg::REG_MODE_OFF || off_cause;
    resource_req = chg_valid || analog_mux_select_in != pwr_seq_pkg::MUX_OFF
      || reg_on_r || reg_req || sink_en_r;
    hr_count_lvl = (key_switch_type_in == pwr_seq_pkg::KEY_PUSH_BUTTON)
      ? ~key.level_n : key.level_n;
    hr_limit = hard_reset_time_sel_in ? 32'(HARD_RST_LONG_CYC - 1)
      : 32'(HARD_RST_SHORT_CYC - 1);
    wake_event = regulator_enable_mode_in == pwr_seq_pkg::REG_MODE_KEY
      && (key.fall || chg_rose);
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    reg_on_nxt = reg_on_r;
    system_register_reset_nxt = 1'b0;
    down_act = 1'b0;
    case (state_r)
      pwr_seq_pkg::st_ship: begin
        reg_on_nxt = 1'b0;
        if (sys_below_exit_in && (chg_rose || ship_key_done_r)) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end
      end
      pwr_seq_pkg::st_shutdown: begin
        // Ship request, then off actions, then reset actions, then wake
        if (software_power_command_in == pwr_seq_pkg::SW_CMD_SHIP) begin
          state_nxt = pwr_seq_pkg::st_ship;
          system_register_reset_nxt = 1'b1;
        end else if (hard_off || software_power_command_in == pwr_seq_pkg::SW_CMD_OFF) begin
          state_nxt = pwr_seq_pkg::st_off_act;
          system_register_reset_nxt = hard_off;
        end else if (software_power_command_in == pwr_seq_pkg::SW_CMD_COLD_RST) begin
          state_nxt = pwr_seq_pkg::st_reset_act;
          system_register_reset_nxt = 1'b1;
        end else if (resource_req && !fault) begin
          state_nxt = pwr_seq_pkg::st_standby;
        end
      end
      pwr_seq_pkg::st_off_act: begin
        // Off command stays pending until software clears it to none or asks for ship
        if (software_power_command_in == pwr_seq_pkg::SW_CMD_SHIP) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end else if (software_power_command_in == pwr_seq_pkg::SW_CMD_NONE) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end
      end
      pwr_seq_pkg::st_reset_act: begin
        if (software_power_command_in != pwr_seq_pkg::SW_CMD_COLD_RST) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end
      end
      pwr_seq_pkg::st_standby: begin
        if (off_cause || !resource_req) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end else begin
          state_nxt = pwr_seq_pkg::st_res_on;
        end
      end
      pwr_seq_pkg::st_res_on: begin
        if (reg_on_r && reg_down_req) begin
          reg_on_nxt = 1'b0;
          down_act = 1'b1;
        end else if (off_cause || !resource_req) begin
          state_nxt = pwr_seq_pkg::st_shutdown;
        end else if (!reg_on_r && reg_req) begin
          reg_on_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = pwr_seq_pkg::st_shutdown;
        reg_on_nxt = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Latched flags and timers
  // ----------------------------------------------------------------
  logic off_act;
  logic rst_act;

  always_comb begin
    off_act = state_r == pwr_seq_pkg::st_off_act;
    rst_act = state_r == pwr_seq_pkg::st_reset_act;
    // Clear beats set in every flag below
    wdt_flag_nxt = wdt_flag_r | watchdog_expire_in;
    if (off_act || rst_act) begin
      wdt_flag_nxt = 1'b0;
    end
    hr_cnt_nxt = '0;
    hr_flag_nxt = hr_flag_r;
    if (hr_count_lvl) begin
      if (hr_cnt_r == hr_limit) begin
        hr_flag_nxt = 1'b1;
        hr_cnt_nxt = hr_cnt_r + 32'h1;
      end else if (hr_cnt_r > hr_limit) begin
        // One hard reset per hold; the key must leave the counting level to re-arm
        hr_cnt_nxt = hr_cnt_r;
      end else begin
        hr_cnt_nxt = hr_cnt_r + 32'h1;
      end
    end
    if (off_act) begin
      hr_flag_nxt = 1'b0;
    end
    reg_wake_nxt = reg_wake_r | wake_event;
    if (down_act || off_act || rst_act) begin
      reg_wake_nxt = 1'b0;
    end
    sw_wake_nxt = sw_wake_r;
    if (rst_act && regulator_enable_default_in == pwr_seq_pkg::REG_MODE_KEY) begin
      sw_wake_nxt = 1'b1;
    end
    if (down_act || off_act) begin
      sw_wake_nxt = 1'b0;
    end
    sink_en_nxt = sink_req;
    ship_cnt_nxt = '0;
    ship_key_done_nxt = 1'b0;
    if (state_r == pwr_seq_pkg::st_ship && !key.level_n) begin
      if (ship_cnt_r == 32'(SHIP_EXIT_CYC - 1)) begin
        ship_key_done_nxt = 1'b1;
        ship_cnt_nxt = ship_cnt_r;
      end else begin
        ship_cnt_nxt = ship_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_r <= pwr_seq_pkg::st_shutdown;
      reg_on_r <= 1'b0;
      system_register_reset_r <= 1'b1;
      wdt_flag_r <= 1'b0;
      hr_flag_r <= 1'b0;
      reg_wake_r <= 1'b0;
      sw_wake_r <= 1'b0;
      sink_en_r <= 1'b0;
      chg_prev_r <= pwr_seq_pkg::CHG_DTLS_NONE;
      hr_cnt_r <= '0;
      ship_cnt_r <= '0;
      ship_key_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      reg_on_r <= reg_on_nxt;
      system_register_reset_r <= system_register_reset_nxt;
      wdt_flag_r <= wdt_flag_nxt;
      hr_flag_r <= hr_flag_nxt;
      reg_wake_r <= reg_wake_nxt;
      sw_wake_r <= sw_wake_nxt;
      sink_en_r <= sink_en_nxt;
      chg_prev_r <= charger_input_details_in;
      hr_cnt_r <= hr_cnt_nxt;
      ship_cnt_r <= ship_cnt_nxt;
      ship_key_done_r <= ship_key_done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign power_state_out = state_r;
  assign bias_enable_out = state_r == pwr_seq_pkg::st_standby
    || state_r == pwr_seq_pkg::st_res_on;
  assign regulator_on_out = reg_on_r;
  assign battery_disconnect_out = state_r == pwr_seq_pkg::st_ship;
  assign host_access_block_out = state_r == pwr_seq_pkg::st_ship;
  assign system_register_reset_out = system_register_reset_r;
  assign sink_final_enable_out = sink_en_r;
  assign watchdog_expired_flag_out = wdt_flag_r;
  assign hard_reset_flag_out = hr_flag_r;
  assign regulator_wake_flag_out = reg_wake_r;
  assign software_wake_flag_out = sw_wake_r;
  assign key_status_mirror_out = key.level_n;
  assign key_rise_irq_out = key.rise;
  assign key_fall_irq_out = key.fall;

endmodule

// File: verif/onkey_model.sv
// Physical on-key model with contact bounce
`timescale 1ns/1ns
module onkey_model #(
  parameter int BOUNCE = 2
) (
  // Clock and press request
  input wire logic clk_in,
  input wire logic press_in,
  // Key line, pulled up while released
  output logic key_n_out
);
  logic press_r = 1'b0;
  int bnc_r = 0;
  initial key_n_out = 1'b1;
  always @(posedge clk_in) begin
    press_r <= press_in;
    if (press_in != press_r) begin
      bnc_r <= BOUNCE;
    end else if (bnc_r != 0) begin
      bnc_r <= bnc_r - 1;
    end
    // Contacts chatter shorter than any debounce time after each change
    key_n_out <= (bnc_r != 0) ? ~key_n_out : ~press_r;
  end
endmodule

// File: verif/power_state_sequencer_sva.sv
// Port assertions for the power-state sequencer
`timescale 1ns/1ns
module power_state_sequencer_sva (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Inputs watched
  input wire logic on_key_n_in,
  input wire logic [1:0] software_power_command_in,
  input wire logic sink_master_enable_in,
  input wire logic [1:0] sink_full_scale_sel_1_in,
  input wire logic [1:0] sink_full_scale_sel_2_in,
  input wire logic watchdog_expire_in,
  input wire logic sys_below_exit_in,
  // Outputs watched
  input wire logic [2:0] power_state_out,
  input wire logic bias_enable_out,
  input wire logic battery_disconnect_out,
  input wire logic host_access_block_out,
  input wire logic system_register_reset_out,
  input wire logic sink_final_enable_out,
  input wire logic watchdog_expired_flag_out,
  input wire logic key_status_mirror_out,
  input wire logic key_rise_irq_out,
  input wire logic key_fall_irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----
  // Sequences
  // ----
  sequence raw_high_s; $past(on_key_n_in, 2) && $past(on_key_n_in, 3); endsequence
  sequence raw_low_s; !$past(on_key_n_in, 2) && !$past(on_key_n_in, 3); endsequence
  sequence ship_entry_s; power_state_out == 3'h0 && $past(power_state_out) != 3'h0; endsequence
  sequence ship_exit_s; power_state_out != 3'h0 && $past(power_state_out) == 3'h0; endsequence
  // ----
  // Assertions
  // ----
  AST_SINK_EN: assert property (!$past(sys_rst_in) |-> sink_final_enable_out ==
    $past(sink_master_enable_in && (sink_full_scale_sel_1_in != 2'h0 ||
    sink_full_scale_sel_2_in != 2'h0))) else $error("sink enable wrong");
  AST_SHIP_BATTERY_NODE: assert property (battery_disconnect_out == (power_state_out == 3'h0))
    else $error("battery disconnect wrong");
  AST_SHIP_HOST: assert property (host_access_block_out == (power_state_out == 3'h0))
    else $error("host block wrong");
  AST_BIAS: assert property (bias_enable_out == (power_state_out inside {3'h4, 3'h5}))
    else $error("bias wrong");
  AST_STANDBY_FIRST: assert property (power_state_out == 3'h5 && $past(power_state_out) != 3'h5
    |-> $past(power_state_out) == 3'h4) else $error("resource-on without standby");
  AST_RISE_IRQ: assert property (key_rise_irq_out |-> key_status_mirror_out ##1 !key_rise_irq_out)
    else $error("rise irq wrong");
  AST_FALL_IRQ: assert property (key_fall_irq_out |-> !key_status_mirror_out ##1 !key_fall_irq_out)
    else $error("fall irq wrong");
  AST_DEB_RISE: assert property ($rose(key_status_mirror_out) |-> raw_high_s)
    else $error("key rise not debounced");
  AST_DEB_FALL: assert property ($fell(key_status_mirror_out) |-> raw_low_s)
    else $error("key fall not debounced");
  AST_SHIP_RST: assert property (ship_entry_s |-> ##[0:1] system_register_reset_out)
    else $error("no register reset on ship entry");
  AST_SHIP_EXIT: assert property (ship_exit_s |-> $past(sys_below_exit_in))
    else $error("ship exit above threshold");
  AST_SHIP_CMD: assert property (power_state_out == 3'h1 && software_power_command_in == 2'h3
    |=> power_state_out == 3'h0) else $error("ship command not taken");
  AST_WDT_SET: assert property (watchdog_expire_in && software_power_command_in == 2'h0 &&
    power_state_out inside {3'h4, 3'h5} |=> watchdog_expired_flag_out) else $error("wdt flag");
endmodule
bind power_state_sequencer power_state_sequencer_sva u_sva (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .on_key_n_in(on_key_n_in),
  .software_power_command_in(software_power_command_in),
  .sink_master_enable_in(sink_master_enable_in),
  .sink_full_scale_sel_1_in(sink_full_scale_sel_1_in),
  .sink_full_scale_sel_2_in(sink_full_scale_sel_2_in),
  .watchdog_expire_in(watchdog_expire_in), .sys_below_exit_in(sys_below_exit_in),
  .power_state_out(power_state_out), .bias_enable_out(bias_enable_out),
  .battery_disconnect_out(battery_disconnect_out), .host_access_block_out(host_access_block_out),
  .system_register_reset_out(system_register_reset_out),
  .sink_final_enable_out(sink_final_enable_out),
  .watchdog_expired_flag_out(watchdog_expired_flag_out),
  .key_status_mirror_out(key_status_mirror_out), .key_rise_irq_out(key_rise_irq_out),
  .key_fall_irq_out(key_fall_irq_out)
);

// File: verif/power_state_sequencer_tb_top.sv
// Self-checking testbench for the power-state sequencer
`timescale 1ns/1ns
module power_state_sequencer_tb_top;
  typedef struct {logic m; logic [1:0] f1; logic [1:0] f2; logic exp;} sink_row_t;
  // ----
  // Signals
  // ----
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic key_press = 1'b0;
  logic db_sel = 1'b0;
  logic key_type = 1'b0;
  logic hr_sel = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [1:0] mode = 2'h2;
  logic [1:0] mode_def = 2'h2;
  logic [3:0] mux = 4'h0;
  logic snk_m = 1'b0;
  logic [1:0] snk_f1 = 2'h0;
  logic [1:0] snk_f2 = 2'h0;
  logic [1:0] chg = 2'h0;
  logic wdt = 1'b0;
  logic otemp = 1'b0;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic below = 1'b0;
  logic key_n;
  logic [2:0] st;
  logic bias, reg_on, battery_node_dis, host_blk, system_register_reset, sink_en, wdt_flag, hr_flag;
  logic rw_flag, sw_flag, mirror, rise_irq, fall_irq;
  logic hr_seen = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  sink_row_t rows[6] = '{'{1'b0, 2'h1, 2'h0, 1'b0}, '{1'b1, 2'h0, 2'h0, 1'b0},
    '{1'b1, 2'h1, 2'h0, 1'b1}, '{1'b1, 2'h0, 2'h2, 1'b1}, '{1'b1, 2'h3, 2'h3, 1'b1},
    '{1'b0, 2'h0, 2'h0, 1'b0}};
  always #10 sys_clk_in = ~sys_clk_in;
  always @(negedge sys_clk_in) if (hr_flag === 1'b1) hr_seen <= 1'b1;
  onkey_model u_key (.clk_in(sys_clk_in), .press_in(key_press), .key_n_out(key_n));
  power_state_sequencer #(.KEY_DB_SHORT_CYC(4), .KEY_DB_LONG_CYC(8), .SHIP_EXIT_CYC(10),
    .HARD_RST_SHORT_CYC(20), .HARD_RST_LONG_CYC(40)) u_dut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .on_key_n_in(key_n),
    .key_debounce_sel_in(db_sel), .key_switch_type_in(key_type), .hard_reset_time_sel_in(hr_sel),
    .software_power_command_in(cmd), .regulator_enable_mode_in(mode),
    .regulator_enable_default_in(mode_def), .analog_mux_select_in(mux),
    .sink_master_enable_in(snk_m), .sink_full_scale_sel_1_in(snk_f1),
    .sink_full_scale_sel_2_in(snk_f2), .charger_input_details_in(chg),
    .watchdog_expire_in(wdt), .overtemp_lockout_in(otemp), .sys_undervoltage_in(uv),
    .sys_overvoltage_in(ov), .sys_below_exit_in(below), .power_state_out(st),
    .bias_enable_out(bias), .regulator_on_out(reg_on), .battery_disconnect_out(battery_node_dis),
    .host_access_block_out(host_blk), .system_register_reset_out(system_register_reset),
    .sink_final_enable_out(sink_en), .watchdog_expired_flag_out(wdt_flag),
    .hard_reset_flag_out(hr_flag), .regulator_wake_flag_out(rw_flag),
    .software_wake_flag_out(sw_flag), .key_status_mirror_out(mirror),
    .key_rise_irq_out(rise_irq), .key_fall_irq_out(fall_irq));
  // ----
  // Tasks
  // ----
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [2:0] probe(input int sel);
    case (sel)
      0: probe = st;
      1: probe = {2'h0, fall_irq};
      2: probe = {2'h0, rise_irq};
      3: probe = {2'h0, hr_flag};
      default: probe = {2'h0, system_register_reset};
    endcase
  endfunction
  // Polls at falling edges until the probe shows the value or the bound runs out
  task automatic wait_for(input int sel, input logic [2:0] val, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (probe(sel) !== val && n < lim);
    check(probe(sel), val);
    if (probe(sel) !== val) complete_run();
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    complete_run();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check({2'h0, system_register_reset}, 3'h1);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    check(st, 3'h1);
    check({1'b0, mirror, wdt_flag | hr_flag | rw_flag | sw_flag}, 3'h2);
    foreach (rows[i]) begin
      @(posedge sys_clk_in);
      snk_m <= rows[i].m;
      snk_f1 <= rows[i].f1;
      snk_f2 <= rows[i].f2;
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      check({2'h0, sink_en}, {2'h0, rows[i].exp});
    end
    wait_for(0, 3'h1, 20);
    @(posedge sys_clk_in);
    mux <= 4'h1;
    wait_for(0, 3'h4, 10);
    check({1'b0, bias, reg_on}, 3'h2);
    wait_for(0, 3'h5, 10);
    @(posedge sys_clk_in);
    mux <= 4'h0;
    wait_for(0, 3'h1, 20);
    @(posedge sys_clk_in);
    key_press <= 1'b1;
    @(posedge sys_clk_in);
    key_press <= 1'b0;
    repeat (12) @(negedge sys_clk_in);
    check({1'b0, mirror, rw_flag}, 3'h2);
    @(posedge sys_clk_in);
    key_press <= 1'b1;
    wait_for(1, 3'h1, 20);
    check({2'h0, mirror}, 3'h0);
    @(negedge sys_clk_in);
    check({2'h0, rw_flag}, 3'h1);
    wait_for(0, 3'h5, 20);
    @(posedge sys_clk_in);
    key_press <= 1'b0;
    wait_for(2, 3'h1, 20);
    check({2'h0, mirror}, 3'h1);
    @(posedge sys_clk_in);
    cmd <= 2'h1;
    wait_for(0, 3'h3, 30);
    repeat (2) @(negedge sys_clk_in);
    check({1'b0, rw_flag, sw_flag}, 3'h1);
    @(posedge sys_clk_in);
    cmd <= 2'h0;
    wait_for(0, 3'h5, 20);
    @(negedge sys_clk_in);
    check({1'b0, bias, reg_on}, 3'h3);
    @(posedge sys_clk_in);
    wdt <= 1'b1;
    @(posedge sys_clk_in);
    wdt <= 1'b0;
    @(negedge sys_clk_in);
    check({2'h0, wdt_flag}, 3'h1);
    wait_for(0, 3'h2, 20);
    wait_for(0, 3'h1, 10);
    check({1'b0, wdt_flag, sw_flag}, 3'h0);
    @(posedge sys_clk_in);
    hr_sel <= 1'b1;
    db_sel <= 1'b1;
    key_press <= 1'b1;
    wait_for(3, 3'h1, 80);
    wait_for(4, 3'h1, 30);
    @(posedge sys_clk_in);
    key_press <= 1'b0;
    wait_for(3, 3'h0, 10);
    repeat (30) @(posedge sys_clk_in);
    hr_seen <= 1'b0;
    repeat (2) begin
      @(posedge sys_clk_in);
      key_press <= 1'b1;
      repeat (30) @(posedge sys_clk_in);
      key_press <= 1'b0;
      repeat (25) @(posedge sys_clk_in);
    end
    @(negedge sys_clk_in);
    check({2'h0, hr_seen}, 3'h0);
    @(posedge sys_clk_in);
    key_type <= 1'b1;
    wait_for(3, 3'h1, 80);
    @(posedge sys_clk_in);
    key_type <= 1'b0;
    mode <= 2'h0;
    repeat (20) @(posedge sys_clk_in);
    wait_for(0, 3'h1, 40);
    @(posedge sys_clk_in);
    cmd <= 2'h3;
    wait_for(0, 3'h0, 5);
    check({1'b0, battery_node_dis, host_blk}, 3'h3);
    @(posedge sys_clk_in);
    cmd <= 2'h0;
    chg <= 2'h3;
    repeat (5) @(negedge sys_clk_in);
    check(st, 3'h0);
    @(posedge sys_clk_in);
    chg <= 2'h0;
    below <= 1'b1;
    @(posedge sys_clk_in);
    chg <= 2'h3;
    wait_for(0, 3'h1, 5);
    wait_for(0, 3'h5, 20);
    @(posedge sys_clk_in);
    otemp <= 1'b1;
    wait_for(0, 3'h1, 20);
    @(posedge sys_clk_in);
    otemp <= 1'b0;
    chg <= 2'h0;
    cmd <= 2'h3;
    wait_for(0, 3'h0, 5);
    @(posedge sys_clk_in);
    cmd <= 2'h0;
    key_press <= 1'b1;
    repeat (15) @(negedge sys_clk_in);
    check(st, 3'h0);
    wait_for(0, 3'h1, 20);
    complete_run();
  end
endmodule
